// *** verilog/memctl_perf_event_select.sv ***
/*
  Event selection for a memory-controller performance counter: dispatch
  queue inserts and depths, link frame kinds and four flow-control slots.
  Assumes the queue exposes its entry state each cycle and the event
  sources give one-cycle pulses, all synchronous to i_clk.
*/
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "perf_sel_defs.svh"

module memctl_perf_event_select #(
  parameter int DEPTH  = 32,
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // register port
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output var  logic [31:0]             o_rdata,
  // dispatch queue
  input  wire logic                    i_ins_valid,
  input  wire logic [ADDR_W-1:0]       i_ins_addr,
  input  wire logic [DEPTH-1:0]        i_q_valid,
  input  wire logic [DEPTH-1:0]        i_q_write,
  input  wire logic [DEPTH*ADDR_W-1:0] i_q_addr,
  // memory-link frames
  input  wire logic                    i_frame_valid,
  input  wire logic [3:0]              i_frame_kind,
  input  wire logic                    i_frame_single,
  // flow-control unit
  input  wire logic                    i_poison,
  input  wire logic                    i_alert,
  input  wire logic                    i_cmd_valid,
  input  wire logic [3:0]              i_cmd_type,
  input  wire logic                    i_rsp_valid,
  input  wire logic [2:0]              i_rsp_type,
  // counter side
  output var  logic [5:0]              o_inc,
  output var  logic [3:0]              o_flow_hit
);
  import perf_sel_pkg::*;

  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [31:0]       event_select_q;
  logic [31:0]       queue_monitor_q;
  logic [31:0]       flow_config_q;
  logic              frame_illegal_q;
  logic [CNT_W-1:0]  read_depth_q;
  logic [CNT_W-1:0]  write_depth_q;

  // register decode
  wire sel_evs  = (i_addr == `OFF_EVENT_SELECT);
  wire sel_qmon = (i_addr == `OFF_QUEUE_MONITOR);
  wire sel_flow = (i_addr == `OFF_FLOW_CONFIG);
  wire sel_stat = (i_addr == `OFF_STATUS);

  wire [7:0] ev_code = event_select_q[`EVS_CODE_HI:`EVS_CODE_LO];
  wire [3:0] frame_sel = event_select_q[`EVS_FRAME_HI:`EVS_FRAME_LO];
  insert_mode_t ins_mode;
  assign ins_mode = insert_mode_t'(event_select_q[`EVS_INS_HI:`EVS_INS_LO]);

  wire [ADDR_W-1:0] match_address_field = queue_monitor_q[ADDR_W-1:0];
  wire [3:0] cmd_sel = flow_config_q[`FLOW_CMD_HI:`FLOW_CMD_LO];
  wire [2:0] rsp_sel = flow_config_q[`FLOW_RSP_HI:`FLOW_RSP_LO];

  // per-entry conflict compare and kind split
  logic [DEPTH-1:0] entry_hit;
  logic [DEPTH-1:0] entry_rd;
  logic [DEPTH-1:0] entry_wr;
  genvar e;
  generate
    for (e = 0; e < DEPTH; e = e + 1) begin : g_entry
      wire [ADDR_W-1:0] ea = i_q_addr[e*ADDR_W +: ADDR_W];
      assign entry_hit[e] = i_q_valid[e] && (ea == i_ins_addr);
      assign entry_rd[e]  = i_q_valid[e] && !i_q_write[e];
      assign entry_wr[e]  = i_q_valid[e] && i_q_write[e];
    end
  endgenerate

  // resident read and write counts
  logic [CNT_W-1:0] read_depth_d;
  logic [CNT_W-1:0] write_depth_d;
  always_comb begin
    read_depth_d  = '0;
    write_depth_d = '0;
    for (int i = 0; i < DEPTH; i++) begin
      read_depth_d  = read_depth_d + CNT_W'(entry_rd[i]);
      write_depth_d = write_depth_d + CNT_W'(entry_wr[i]);
    end
  end

  // insert flavours
  wire ins_conflict = i_ins_valid && (|entry_hit);
  wire ins_match    = i_ins_valid && (i_ins_addr == match_address_field);
  logic ins_hit;
  always_comb begin
    case (ins_mode)
      INS_PLAIN:          ins_hit = i_ins_valid;
      INS_CONFLICT:       ins_hit = ins_conflict;
      INS_MATCH:          ins_hit = ins_match;
      INS_MATCH_CONFLICT: ins_hit = ins_match && ins_conflict;
      default:            ins_hit = 1'b0;
    endcase
  end

  // frame kinds; illegal selections count nothing
  wire frame_legal =
    (frame_sel == `FRM_TRIPLE_CMD) || (frame_sel == `FRM_WRITE_PAYLOAD) ||
    (frame_sel == `FRM_SYNC) || (frame_sel == `FRM_CHANNEL) ||
    (frame_sel == `FRM_NOP) || (frame_sel == `FRM_SINGLE_CMD);
  wire frame_hit_single = i_frame_valid && i_frame_single &&
                          (frame_sel == `FRM_SINGLE_CMD);
  wire frame_hit_kind = i_frame_valid && frame_legal &&
                        (frame_sel != `FRM_SINGLE_CMD) &&
                        (i_frame_kind == frame_sel);
  wire frame_hit = frame_hit_single || frame_hit_kind;

  // shared qualifiers for command and response matching
  wire cmd_hit = i_cmd_valid && (i_cmd_type == cmd_sel);
  // a retry response is one pulse per retry, so each one counts
  wire rsp_hit = i_rsp_valid && (i_rsp_type == rsp_sel) &&
                 (rsp_sel != `RSP_NOTHING);

  // four independent flow slots
  logic [3:0] flow_hit_d;
  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : g_slot
      wire [3:0] psel =
        flow_config_q[`FLOW_SLOT0_LO + s*`FLOW_SLOT_W +: `FLOW_SLOT_W];
      assign flow_hit_d[s] =
        (psel == `FSEL_POISON)    ? i_poison :
        (psel == `FSEL_ALERT)     ? i_alert :
        (psel == `FSEL_NOTHING)   ? 1'b0 :
        (psel == `FSEL_COMMANDS)  ? cmd_hit :
        (psel == `FSEL_RESPONSES) ? rsp_hit : 1'b0;
    end
  endgenerate

  // increment toward the counter
  wire is_read_depth  = (ev_code == `EV_READ_DEPTH);
  wire is_write_depth = (ev_code == `EV_WRITE_DEPTH);
  wire one_bit_hit =
    (ev_code == `EV_QUEUE_INSERT) ? ins_hit :
    (ev_code == `EV_FRAME_KIND)   ? frame_hit :
    (ev_code == `EV_FLOW_SLOT0)   ? flow_hit_d[0] :
    (ev_code == `EV_FLOW_SLOT1)   ? flow_hit_d[1] :
    (ev_code == `EV_FLOW_SLOT2)   ? flow_hit_d[2] :
    (ev_code == `EV_FLOW_SLOT3)   ? flow_hit_d[3] : 1'b0;
  wire [5:0] inc_d =
    is_read_depth  ? 6'(read_depth_d) :
    is_write_depth ? 6'(write_depth_d) :
    6'(one_bit_hit);

  // read mux; unmapped addresses read zero
  wire [31:0] status_word =
    {15'h0000, frame_illegal_q, 8'(write_depth_q), 8'(read_depth_q)};
  wire [31:0] rdata_d =
    sel_evs  ? event_select_q :
    sel_qmon ? queue_monitor_q :
    sel_flow ? flow_config_q :
    sel_stat ? status_word : 32'h0000_0000;

  // software-programmed configuration
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      event_select_q  <= `RST_EVENT_SELECT;
      queue_monitor_q <= `RST_QUEUE_MONITOR;
      flow_config_q   <= `RST_FLOW_CONFIG;
    end else if (i_wr) begin
      if (sel_evs) begin
        event_select_q <= i_wdata;
      end
      if (sel_qmon) begin
        queue_monitor_q <= i_wdata;
      end
      if (sel_flow) begin
        flow_config_q <= i_wdata;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? rdata_d : 32'h0000_0000;
    end
  end

  // observed state and counter outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      read_depth_q    <= '0;
      write_depth_q   <= '0;
      frame_illegal_q <= 1'b0;
      o_inc           <= 6'h00;
      o_flow_hit      <= 4'h0;
    end else begin
      read_depth_q    <= read_depth_d;
      write_depth_q   <= write_depth_d;
      frame_illegal_q <= (ev_code == `EV_FRAME_KIND) && !frame_legal;
      o_inc           <= inc_d;
      o_flow_hit      <= flow_hit_d;
    end
  end

endmodule // memctl_perf_event_select
`default_nettype wire

// *** verilog/perf_sel_defs.svh ***
/*
  Offsets, field positions, event codes and reset values for the
  memory-controller performance event selector.
  Assumes a 32-bit register port with byte offsets on word boundaries.
*/
`ifndef PERF_SEL_DEFS_SVH
`define PERF_SEL_DEFS_SVH

// register offsets (byte address)
`define OFF_EVENT_SELECT   8'h00
`define OFF_QUEUE_MONITOR  8'h04
`define OFF_FLOW_CONFIG    8'h08
`define OFF_STATUS         8'h0c

// event_select fields
`define EVS_CODE_HI        7
`define EVS_CODE_LO        0
`define EVS_INS_HI         9
`define EVS_INS_LO         8
`define EVS_FRAME_HI       13
`define EVS_FRAME_LO       10

// flow_event_config fields
`define FLOW_CMD_LO        5
`define FLOW_CMD_HI        8
`define FLOW_RSP_LO        9
`define FLOW_RSP_HI        11
`define FLOW_SLOT0_LO      12
`define FLOW_SLOT_W        4

// event codes
`define EV_QUEUE_INSERT    8'h28
`define EV_READ_DEPTH      8'h3b
`define EV_WRITE_DEPTH     8'h3f
`define EV_FRAME_KIND      8'h09
`define EV_FLOW_SLOT0      8'h0d
`define EV_FLOW_SLOT1      8'h0e
`define EV_FLOW_SLOT2      8'h0f
`define EV_FLOW_SLOT3      8'h10

// frame selector codes
`define FRM_TRIPLE_CMD     4'h0
`define FRM_WRITE_PAYLOAD  4'h1
`define FRM_SYNC           4'h2
`define FRM_CHANNEL        4'h3
`define FRM_NOP            4'h8
`define FRM_SINGLE_CMD     4'hc

// flow primary selector codes
`define FSEL_POISON        4'h2
`define FSEL_ALERT         4'h3
`define FSEL_NOTHING       4'h4
`define FSEL_COMMANDS      4'h5
`define FSEL_RESPONSES     4'h6

// response outcome codes
`define RSP_RETRY          3'h1
`define RSP_NOTHING        3'h6

// reset values
`define RST_EVENT_SELECT   32'h0000_0000
`define RST_QUEUE_MONITOR  32'h0000_0000
`define RST_FLOW_CONFIG    32'h0000_0000

`endif

// *** verilog/perf_sel_pkg.sv ***
/*
  Types for the memory-controller performance event selector.
  Assumes perf_sel_defs.svh carries the numeric constants.
*/
`default_nettype none
package perf_sel_pkg;
  // insert-event flavours sharing one event code
  typedef enum logic [1:0] {
    INS_PLAIN,
    INS_CONFLICT,
    INS_MATCH,
    INS_MATCH_CONFLICT
  } insert_mode_t;
endpackage
`default_nettype wire

// *** tb/perf_counter_model.sv ***
/*
  Counter-side model: accumulates the selected increment every cycle.
  Assumes one clock and the block's async active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module perf_counter_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // increment in, running total out
  input  wire logic [5:0]  i_inc,
  output var  logic [31:0] o_total
);
  // wide total so a full-depth run never wraps
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_total <= 32'h0;
    else o_total <= o_total + 32'(i_inc);
  end
endmodule // perf_counter_model
`default_nettype wire

// *** tb/perf_sel_chk.sv ***
/*
  Checker for the event selector, bound to its top module.
  Assumes it sees only top-level ports; config is shadowed from writes.
*/
`timescale 1ns/1ns
`default_nettype none
module perf_sel_chk #(
  parameter int DEPTH  = 32,
  parameter int ADDR_W = 32
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  input wire logic [7:0]              i_addr,
  input wire logic [31:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [31:0]             o_rdata,
  input wire logic                    i_ins_valid,
  input wire logic [ADDR_W-1:0]       i_ins_addr,
  input wire logic [DEPTH-1:0]        i_q_valid,
  input wire logic [DEPTH-1:0]        i_q_write,
  input wire logic [DEPTH*ADDR_W-1:0] i_q_addr,
  input wire logic                    i_poison,
  input wire logic                    i_rsp_valid,
  input wire logic [2:0]              i_rsp_type,
  input wire logic [5:0]              o_inc,
  input wire logic [3:0]              o_flow_hit
);
  logic [31:0] evs_q, flw_q;
  logic [ADDR_W-1:0] mon_q;
  logic hit;
  wire logic [7:0] code = evs_q[7:0];
  wire logic [1:0] mode = evs_q[9:8];
  wire logic [3:0] s0 = flw_q[15:12];
  wire logic [5:0] n_rd = 6'($countones(i_q_valid & ~i_q_write));
  wire logic [5:0] n_wr = 6'($countones(i_q_valid & i_q_write));
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      evs_q <= '0;
      flw_q <= '0;
      mon_q <= '0;
    end else if (i_wr) begin
      if (i_addr == 8'h00) evs_q <= i_wdata;
      if (i_addr == 8'h04) mon_q <= i_wdata[ADDR_W-1:0];
      if (i_addr == 8'h08) flw_q <= i_wdata;
    end
  end
  always_comb begin
    hit = 1'b0;
    for (int e = 0; e < DEPTH; e++) if (i_q_valid[e] && i_q_addr[e*ADDR_W +: ADDR_W] == i_ins_addr) hit = 1'b1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_read_gap: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside slot");
  a_plain_insert: assert property (code == 8'h28 && mode == 2'd0 && i_ins_valid |=> o_inc == 6'h1)
    else $error("plain insert not counted");
  a_conflict_ins: assert property (code == 8'h28 && mode == 2'd1 && i_ins_valid |=> o_inc == {5'h0, $past(hit)})
    else $error("conflict insert miscounted");
  a_match_miss: assert property (code == 8'h28 && mode[1] && i_ins_valid && i_ins_addr != mon_q |=> o_inc == 6'h0)
    else $error("unmatched insert counted");
  a_read_depth: assert property (code == 8'h3b |=> o_inc == $past(n_rd)) else $error("read depth wrong");
  a_write_depth: assert property (code == 8'h3f |=> o_inc == $past(n_wr)) else $error("write depth wrong");
  a_frame_bad: assert property (code == 8'h09 && evs_q[13:10] inside {[4'h4:4'h7], [4'h9:4'hb], [4'hd:4'hf]}
    |=> o_inc == 6'h0) else $error("illegal frame selector counted");
  a_slot_quiet: assert property (s0 == 4'h4 |=> !o_flow_hit[0]) else $error("empty selector hit");
  a_poison_slot: assert property (s0 == 4'h2 |=> o_flow_hit[0] == $past(i_poison)) else $error("poison miss");
  a_retry_resp: assert property (s0 == 4'h6 && flw_q[11:9] == 3'h1 && i_rsp_valid && i_rsp_type == 3'h1
    |=> o_flow_hit[0]) else $error("retry not counted");
endmodule // perf_sel_chk
bind memctl_perf_event_select perf_sel_chk #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// *** tb/test_memctl_perf_event_select.sv ***
/*
  Self-checking bench: one task per scenario, judged at the ports.
  Assumes the design, counter model and bound checker compile first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_memctl_perf_event_select;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_ins_valid = 0, i_frame_valid = 0, i_frame_single = 0;
  logic i_poison = 0, i_alert = 0, i_cmd_valid = 0, i_rsp_valid = 0;
  logic [7:0] i_addr = 0;
  logic [31:0] i_wdata = 0, i_ins_addr = 0, i_q_valid = 0, i_q_write = 0, o_rdata, total, t0, d;
  logic [1023:0] i_q_addr = '0;
  logic [3:0] i_frame_kind = 0, i_cmd_type = 0, o_flow_hit;
  logic [2:0] i_rsp_type = 0;
  logic [5:0] o_inc;
  logic [3:0] k [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8};
  int error_cnt = 0, n_tests = 0, cyc = 0;
  memctl_perf_event_select i_dut (.*);
  perf_counter_model u_cnt (.i_clk(i_clk), .i_rst(i_rst), .i_inc(o_inc), .o_total(total));
  initial forever #5 i_clk = ~i_clk;
  // whole run needs well under 2000 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin error_cnt++; report_and_stop(); end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk) begin i_wr <= 1; i_addr <= a; i_wdata <= v; end
    @(posedge i_clk) i_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk) begin i_rd <= 1; i_addr <= a; end
    @(posedge i_clk) i_rd <= 0;
    #1 d = o_rdata;
  endtask
  task automatic settle();
    @(posedge i_clk) begin
      {i_ins_valid, i_frame_valid, i_poison, i_alert, i_cmd_valid, i_rsp_valid} <= '0;
    end
    #1;
  endtask
  task automatic ins(input logic [1:0] m, input logic [31:0] a, input logic [5:0] e);
    wr(8'h00, {22'h0, m, 8'h28});
    @(posedge i_clk) begin i_ins_valid <= 1; i_ins_addr <= a; end
    settle(); `CHK(o_inc, e)
  endtask
  task automatic frm(input logic [3:0] kd, input logic s, input logic [5:0] e);
    @(posedge i_clk) begin i_frame_valid <= 1; i_frame_kind <= kd; i_frame_single <= s; end
    settle(); `CHK(o_inc, e)
  endtask
  task automatic fl(input logic [3:0] v, input logic [3:0] ct, input logic [2:0] rt, input logic [3:0] e);
    @(posedge i_clk) begin {i_rsp_valid, i_cmd_valid, i_alert, i_poison} <= v; i_cmd_type <= ct; i_rsp_type <= rt; end
    settle(); `CHK(o_flow_hit, e)
  endtask
  task automatic t_regs();
    rd(8'h08); `CHK(d, 32'h0)
    wr(8'h08, 32'h0abc_d1e0); rd(8'h08); `CHK(d, 32'h0abc_d1e0)
    wr(8'h20, 32'h1); rd(8'h20); `CHK(d, 32'h0)
  endtask
  task automatic t_insert();
    @(posedge i_clk) begin i_q_valid <= 32'h1; i_q_addr[31:0] <= 32'h4560; end
    wr(8'h04, 32'h99);
    ins(2'd0, 32'h77, 6'h1);
    ins(2'd1, 32'h4560, 6'h1); ins(2'd1, 32'h99, 6'h0);
    ins(2'd2, 32'h99, 6'h1); ins(2'd2, 32'h4560, 6'h0);
    ins(2'd3, 32'h99, 6'h0); ins(2'd3, 32'h4560, 6'h0);
    wr(8'h04, 32'h4560); ins(2'd3, 32'h4560, 6'h1);
    @(posedge i_clk) i_q_valid <= 32'h0;
    ins(2'd1, 32'h4560, 6'h0);
  endtask
  task automatic t_depth();
    @(posedge i_clk) begin i_q_valid <= 32'hffff_00ff; i_q_write <= 32'h3; end
    wr(8'h00, 32'h3b); repeat (2) @(posedge i_clk); #1 `CHK(o_inc, 6'd22)
    t0 = total; repeat (4) @(posedge i_clk); #1 `CHK(total - t0, 32'd88)
    wr(8'h00, 32'h3f); repeat (2) @(posedge i_clk); #1 `CHK(o_inc, 6'd2)
    rd(8'h0c); `CHK(d[15:0], 16'h0216)
    @(posedge i_clk) begin i_q_valid <= '1; i_q_write <= '0; end
    wr(8'h00, 32'h3b); repeat (2) @(posedge i_clk); #1 `CHK(o_inc, 6'd32)
    @(posedge i_clk) i_q_valid <= '0;
  endtask
  task automatic t_frames();
    foreach (k[i]) begin
      wr(8'h00, {18'h0, k[i], 10'h09});
      frm(k[i], 0, 6'h1); frm(k[(i + 1) % 5], 0, 6'h0);
    end
    wr(8'h00, {18'h0, 4'hc, 10'h09}); frm(4'h0, 1, 6'h1); frm(4'h1, 0, 6'h0);
    for (int s = 4; s < 16; s += 5) begin
      wr(8'h00, {18'h0, 4'(s), 10'h09}); frm(4'h8, 1, 6'h0); rd(8'h0c); `CHK(d[16], 1'b1)
    end
  endtask
  task automatic t_flow();
    wr(8'h00, 32'h0d);
    wr(8'h08, 32'h0543_2000);
    fl(4'h1, 0, 0, 4'b0001); `CHK(o_inc, 6'h1)
    fl(4'h2, 0, 0, 4'b0010); fl(4'h3, 0, 0, 4'b0011);
    wr(8'h00, 32'h0e); fl(4'h2, 0, 0, 4'b0010); `CHK(o_inc, 6'h1)
    wr(8'h00, 32'h0f); fl(4'h2, 0, 0, 4'b0010); `CHK(o_inc, 6'h0)
    wr(8'h00, 32'h0d);
    for (int c = 0; c < 16; c++) begin
      wr(8'h08, {4'h0, 4'h5, 15'h0, 4'(c), 5'h0});
      fl(4'h4, 4'(c), 0, 4'b1000); fl(4'h4, 4'(c + 1), 0, 4'b0000);
    end
    for (int r = 0; r < 8; r++) begin
      wr(8'h08, {16'h0, 4'h6, 3'(r), 9'h0});
      fl(4'h8, 0, 3'(r), {3'b0, r != 6}); fl(4'h8, 0, 3'(r + 1), 4'b0000);
    end
    wr(8'h08, {16'h0, 4'h6, 3'h1, 9'h0});
    @(posedge i_clk) begin i_rsp_valid <= 1; i_rsp_type <= 3'h1; end
    @(posedge i_clk); #1 `CHK(o_flow_hit, 4'b0001)
    settle(); `CHK(o_flow_hit, 4'b0001)
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 0;
    t_regs();
    t_insert();
    t_depth();
    t_frames();
    t_flow();
    report_and_stop();
  end
endmodule // test_memctl_perf_event_select
`default_nettype wire
